// >>> common/hbr_pkg.sv
// How it works
// - Write-one-to-clear bits clear on a one and ignore a zero.
// - Six-bit bank choice field, reset zero, selects one of 64 banks.
// - Bank selector answers at offset 0x0E in every bank.
// - Selector reached as dword at 0xC, or word or byte at 0xE.
// - Dword write at 0xC changes only the selector, never 0xC or 0xD.
// - Strap high at reset loads base address from EEPROM word zero.
// - Base address stays host writable; host writes never touch EEPROM.
// - Strap low resets base address to 0x300.
// - Access is ours when base bits 15:8 and 7:5 match address bits.
// - Watermark bit 12: zero selects 3 KB, one selects 2 KB; resets zero.
// - Illegal byte enables set bit 15 and capture enables in bits 14:11.
// - Simultaneous sync and async transfers set bit 10; one clears it.
// - Burst field 14:12: single, 4, 8 or 16 beats; resets zero.
// - Bank 1 holds nothing except the bank selector.
// - Strap high at reset also loads MAC words one to three into low, middle, high.
// - Host may rewrite MAC registers; EEPROM copy stays unchanged.
// - Bank 2 offset 0x00 holds the low MAC address word.
// - Middle and high MAC words sit at bank 2 offsets 0x02 and 0x04.
//
// Purpose: Constants, carriers and state for the banked host register block.
// Assumes: Host bus pins are synchronised inside the block.
// Notes:   Offsets are byte offsets within the 16-byte I/O window.
package hbr_pkg;

	// ----------------------------------------------------------------
	// Offsets, banks and field layout
	// ----------------------------------------------------------------
	localparam logic [3:0]  OFF_BASE      = 4'h0;
	localparam logic [3:0]  OFF_WMARK     = 4'h4;
	localparam logic [3:0]  OFF_BUS_ERR   = 4'h6;
	localparam logic [3:0]  OFF_BURST     = 4'h8;
	localparam logic [3:0]  OFF_BANK_SEL  = 4'hE;
	localparam logic [3:0]  OFF_DWORD_SEL = 4'hC;
	localparam logic [3:0]  OFF_MAC_LOW   = 4'h0;
	localparam logic [3:0]  OFF_MAC_MID   = 4'h2;
	localparam logic [3:0]  OFF_MAC_HIGH  = 4'h4;
	localparam logic [5:0]  BANK_CTRL     = 6'h00;
	localparam logic [5:0]  BANK_MAC      = 6'h02;
	localparam logic [15:0] MASK_BASE     = 16'hFFE0;
	localparam logic [15:0] MASK_BANK     = 16'h003F;
	localparam logic [15:0] MASK_WMARK    = 16'h1000;
	localparam logic [15:0] MASK_BURST    = 16'h7000;
	localparam int          POS_WMARK     = 12;
	localparam int          POS_BURST     = 12;
	localparam int          POS_ILLEGAL_BYTE_ENABLE_FLAG      = 15;
	localparam int          POS_ILLEGAL_BYTE_ENABLE_VALUE     = 11;
	localparam int          POS_MIXED     = 10;

	// ----------------------------------------------------------------
	// Reset values and load timing
	// ----------------------------------------------------------------
	localparam logic [15:0] BASE_DEFAULT  = 16'h0300;
	localparam logic [5:0]  BANK_RESET    = 6'h00;
	localparam logic [2:0]  BURST_RESET   = 3'h0;
	localparam logic [1:0]  EE_WORD_BASE  = 2'h0;
	localparam logic [1:0]  EE_WORD_LAST  = 2'h3;
	localparam logic [1:0]  LOAD_SETTLE   = 2'h3;

	// Loader states
	typedef enum logic [1:0] {LD_SETTLE, LD_REQ, LD_WAIT, LD_IDLE} hbr_load_t;

	// Host bus pins as one group
	typedef struct packed {
		logic [15:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} hbr_host_req_t;

	// Whole state of the register block
	typedef struct packed {
		hbr_host_req_t req_s1;
		hbr_host_req_t req_s2;
		logic          wr_prev;
		logic          rd_prev;
		logic [1:0]    sync_sh;
		logic [1:0]    async_sh;
		logic [1:0]    strap_sh;
		hbr_load_t     ld;
		logic          ld_busy;
		logic [1:0]    ld_cnt;
		logic          ee_req;
		logic [5:0]    bank;
		logic [15:0]   base;
		logic          wmark;
		logic          illegal_byte_enable_flag;
		logic [3:0]    illegal_byte_enable_value;
		logic          mixed;
		logic [2:0]    burst;
		logic [15:0]   mac_low;
		logic [15:0]   mac_mid;
		logic [15:0]   mac_high;
		logic [31:0]   rdata;
		logic          rvalid;
	} hbr_state_t;

endpackage : hbr_pkg

// >>> src/hbr_banked_regs.sv
// Purpose: Banked host register block: bank select, base decode, bus errors,
//          watermark and burst setup, MAC address words with EEPROM preload.
// Assumes: Host pins are asynchronous and held stable across a strobe;
//          the EEPROM word reader runs on CLK.
// Notes:   Host accesses are ignored while the preload runs.
`timescale 1ns/1ps
module hbr_banked_regs
	import hbr_pkg::*;
(
	input  wire logic          CLK,
	input  wire logic          SRST,
	input  wire hbr_host_req_t HOST_REQ,
	input  wire logic          HOST_SYNC_XFER,
	input  wire logic          HOST_ASYNC_XFER,
	input  wire logic          EEPROM_ENABLE_PIN,
	input  wire logic          EE_ACK,
	input  wire logic [15:0]   EE_DATA,
	output logic [31:0]        HOST_RDATA,
	output logic               HOST_RVALID,
	output logic               LOAD_BUSY,
	output logic               EE_REQ,
	output logic [1:0]         EE_WORD,
	output logic [5:0]         BANK_SELECT,
	output logic               RX_WM_2KB,
	output logic [2:0]         BURST_LENGTH,
	output logic [47:0]        HOST_MAC
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Byte-lane merge limited to the writable bits
	function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] be, input logic [15:0] msk);
		logic [15:0] bm;
		bm = {{8{be[1]}}, {8{be[0]}}} & msk;
		return (old_v & ~bm) | (new_v & bm);
	endfunction : lane_merge

	// Only single bytes, aligned halves and the full dword are legal
	function automatic logic be_legal(input logic [3:0] be);
		logic ok;
		ok = 1'b0;
		unique case (be)
			4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : be_legal

	// Write one 16-bit half; reserved bits never change
	function automatic hbr_state_t half_write(input hbr_state_t s,
		input logic [3:0] off, input logic [15:0] d, input logic [1:0] be);
		hbr_state_t r;
		logic [15:0] t;
		r = s;
		t = 16'h0000;
		// selector ahead of any bank decode
		if (off == OFF_BANK_SEL) begin
			t = lane_merge({10'h000, s.bank}, d, be, MASK_BANK);
			r.bank = t[5:0];
		end else if (s.bank == BANK_CTRL) begin
			unique case (off)
				OFF_BASE: begin
					r.base = lane_merge(s.base, d, be, MASK_BASE);
				end
				OFF_WMARK: begin
					t = lane_merge({3'h0, s.wmark, 12'h000}, d, be, MASK_WMARK);
					r.wmark = t[POS_WMARK];
				end
				OFF_BUS_ERR: begin
					// a one clears, a zero leaves the flag
					if (be[1] && d[POS_ILLEGAL_BYTE_ENABLE_FLAG])
						r.illegal_byte_enable_flag = 1'b0;
					if (be[1] && d[POS_MIXED])
						r.mixed = 1'b0;
				end
				OFF_BURST: begin
					t = lane_merge({1'b0, s.burst, 12'h000}, d, be, MASK_BURST);
					r.burst = t[POS_BURST +: 3];
				end
				default: r = s;
			endcase
		end else if (s.bank == BANK_MAC) begin
			// host may rewrite all three MAC words
			unique case (off)
				OFF_MAC_LOW:  r.mac_low  = lane_merge(s.mac_low, d, be, 16'hFFFF);
				OFF_MAC_MID:  r.mac_mid  = lane_merge(s.mac_mid, d, be, 16'hFFFF);
				OFF_MAC_HIGH: r.mac_high = lane_merge(s.mac_high, d, be, 16'hFFFF);
				default:      r = s;
			endcase
		end
		return r;
	endfunction : half_write

	// Read one 16-bit half; reserved bits and empty banks read zero
	function automatic logic [15:0] half_read(input hbr_state_t s, input logic [3:0] off);
		logic [15:0] v;
		v = 16'h0000;
		// bank 1 and unused banks show only the selector
		if (off == OFF_BANK_SEL) begin
			v = {10'h000, s.bank};
		end else if (s.bank == BANK_CTRL) begin
			unique case (off)
				OFF_BASE:    v = s.base & MASK_BASE;
				OFF_WMARK:   v = {3'h0, s.wmark, 12'h000};
				OFF_BUS_ERR: v = {s.illegal_byte_enable_flag, s.illegal_byte_enable_value, s.mixed, 10'h000};
				OFF_BURST:   v = {1'b0, s.burst, 12'h000};
				default:     v = 16'h0000;
			endcase
		end else if (s.bank == BANK_MAC) begin
			unique case (off)
				OFF_MAC_LOW:  v = s.mac_low;
				OFF_MAC_MID:  v = s.mac_mid;
				OFF_MAC_HIGH: v = s.mac_high;
				default:      v = 16'h0000;
			endcase
		end
		return v;
	endfunction : half_read

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	hbr_state_t r_q;
	hbr_state_t r_d;
	logic       wr_ev;
	logic       rd_ev;
	logic       hit;
	logic       legal;
	logic       busy;
	logic       mixed_ev;
	logic [3:0] off_lo;
	logic [3:0] off_hi;

	// Strobe edges seen only on the second sync stage
	assign wr_ev = r_q.req_s2.wr && !r_q.wr_prev;
	assign rd_ev = r_q.req_s2.rd && !r_q.rd_prev;
	assign busy  = r_q.ld_busy;
	// compare base bits 15:8 and 7:5
	assign hit   = (r_q.req_s2.addr[15:8] == r_q.base[15:8])
		&& (r_q.req_s2.addr[7:5] == r_q.base[7:5]);
	assign legal = be_legal(r_q.req_s2.be);
	// dword index picks 0xC, halves reach 0xE
	assign off_lo = {r_q.req_s2.addr[3:2], 2'b00};
	assign off_hi = {r_q.req_s2.addr[3:2], 2'b10};
	assign mixed_ev = r_q.sync_sh[1] && r_q.async_sh[1];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		// Two-stage synchronisers; stage one feeds stage two only
		r_d.req_s1   = HOST_REQ;
		r_d.req_s2   = r_q.req_s1;
		r_d.wr_prev  = r_q.req_s2.wr;
		r_d.rd_prev  = r_q.req_s2.rd;
		r_d.sync_sh  = {r_q.sync_sh[0], HOST_SYNC_XFER};
		r_d.async_sh = {r_q.async_sh[0], HOST_ASYNC_XFER};
		r_d.strap_sh = {r_q.strap_sh[0], EEPROM_ENABLE_PIN};
		r_d.rvalid   = 1'b0;

		// Preload: strap sampled once the synchroniser has settled
		unique case (r_q.ld)
			LD_SETTLE: begin
				r_d.ld_cnt = r_q.ld_cnt + 2'h1;
				if (r_q.ld_cnt == LOAD_SETTLE) begin
					r_d.ld_cnt = EE_WORD_BASE;
					// strap low keeps the 0x300 default
					r_d.ld = r_q.strap_sh[1] ? LD_REQ : LD_IDLE;
				end
			end
			LD_REQ: begin
				r_d.ee_req = 1'b1;
				r_d.ld     = LD_WAIT;
			end
			LD_WAIT: begin
				if (EE_ACK) begin
					r_d.ee_req = 1'b0;
					// word zero is the base address
					// words one to three are the MAC words
					unique case (r_q.ld_cnt)
						2'h0: r_d.base     = EE_DATA & MASK_BASE;
						2'h1: r_d.mac_low  = EE_DATA;
						2'h2: r_d.mac_mid  = EE_DATA;
						2'h3: r_d.mac_high = EE_DATA;
					endcase
					r_d.ld_cnt = r_q.ld_cnt + 2'h1;
					r_d.ld = (r_q.ld_cnt == EE_WORD_LAST) ? LD_IDLE : LD_REQ;
				end
			end
			LD_IDLE: r_d.ld_cnt = r_q.ld_cnt;
		endcase
		// Busy kept in a flop so the port comes straight from one
		r_d.ld_busy = (r_d.ld != LD_IDLE);

		// Host accesses, refused while loading
		if (!busy && hit && (wr_ev || rd_ev)) begin
			if (!legal) begin
				// first capture held while flag stays set
				if (!r_q.illegal_byte_enable_flag)
					r_d.illegal_byte_enable_value = r_q.req_s2.be;
				r_d.illegal_byte_enable_flag = 1'b1;
				r_d.rvalid = rd_ev;
				r_d.rdata  = 32'h0000_0000;
			end else if (wr_ev) begin
				// 0xC half holds nothing, so only 0xE changes
				if (|r_q.req_s2.be[1:0])
					r_d = half_write(r_d, off_lo, r_q.req_s2.wdata[15:0],
						r_q.req_s2.be[1:0]);
				if (|r_q.req_s2.be[3:2])
					r_d = half_write(r_d, off_hi, r_q.req_s2.wdata[31:16],
						r_q.req_s2.be[3:2]);
			end else begin
				// Unselected byte lanes read as zero
				r_d.rvalid = 1'b1;
				r_d.rdata  = {half_read(r_q, off_hi), half_read(r_q, off_lo)}
					& {{8{r_q.req_s2.be[3]}}, {8{r_q.req_s2.be[2]}},
					{8{r_q.req_s2.be[1]}}, {8{r_q.req_s2.be[0]}}};
			end
		end

		// set wins over a same-cycle clear
		if (mixed_ev)
			r_d.mixed = 1'b1;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			r_q          <= '0;
			r_q.ld       <= LD_SETTLE;
			r_q.ld_busy  <= 1'b1;
			r_q.bank     <= BANK_RESET;
			r_q.base     <= BASE_DEFAULT;
			r_q.wmark    <= 1'b0;
			r_q.burst    <= BURST_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	// Ports straight from the state register
	assign HOST_RDATA   = r_q.rdata;
	assign HOST_RVALID  = r_q.rvalid;
	assign LOAD_BUSY    = busy;
	assign EE_REQ       = r_q.ee_req;
	assign EE_WORD      = r_q.ld_cnt;
	assign BANK_SELECT  = r_q.bank;
	// one selects the 2 KB watermark
	assign RX_WM_2KB    = r_q.wmark;
	// burst code handed to the transfer engine
	assign BURST_LENGTH = r_q.burst;
	assign HOST_MAC     = {r_q.mac_high, r_q.mac_mid, r_q.mac_low};

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	logic acc_ok;
	logic illegal_byte_enable_flag_clr;
	assign acc_ok   = !busy && hit && legal;
	assign illegal_byte_enable_flag_clr = acc_ok && wr_ev && r_q.bank == BANK_CTRL
		&& r_q.req_s2.addr[3:2] == 2'h1 && r_q.req_s2.be[3]
		&& r_q.req_s2.wdata[31];

	sequence s_sel_word_wr;
		acc_ok && wr_ev && r_q.req_s2.addr[3:2] == 2'h3 && r_q.req_s2.be[2];
	endsequence

	sequence s_illegal_first;
		!busy && hit && !legal && (wr_ev || rd_ev) && !r_q.illegal_byte_enable_flag;
	endsequence

	a_bank_any: assert property (s_sel_word_wr |=>
		BANK_SELECT == $past(r_q.req_s2.wdata[21:16]))
		else $error("bank selector write lost");
	a_dword_c_only: assert property (s_sel_word_wr ##0 r_q.req_s2.be == 4'hF |=>
		$stable(r_q.base) && $stable(r_q.mac_low) && $stable(r_q.wmark))
		else $error("dword selector write touched another register");
	a_illegal_byte_enable_flag_capture: assert property (s_illegal_first |=>
		r_q.illegal_byte_enable_flag && r_q.illegal_byte_enable_value == $past(r_q.req_s2.be))
		else $error("illegal byte enable not captured");
	a_illegal_byte_enable_flag_hold: assert property (r_q.illegal_byte_enable_flag && !illegal_byte_enable_flag_clr |=>
		r_q.illegal_byte_enable_flag && $stable(r_q.illegal_byte_enable_value))
		else $error("bus error flag or value changed");
	a_w1c_clear: assert property (illegal_byte_enable_flag_clr |=> !r_q.illegal_byte_enable_flag)
		else $error("write one did not clear flag");
	a_mixed_set: assert property (mixed_ev |=> r_q.mixed [*1])
		else $error("mixed transfer not flagged");
	a_decode_hit: assert property (HOST_RVALID |-> $past(hit) && $past(rd_ev))
		else $error("answer to a foreign address");
	a_base_default: assert property ($fell(busy) && !$past(r_q.strap_sh[1]) |->
		r_q.base == BASE_DEFAULT)
		else $error("base address not defaulted");
	a_load_base: assert property (r_q.ld == LD_WAIT && EE_ACK && r_q.ld_cnt == 2'h0 |=>
		r_q.base == ($past(EE_DATA) & MASK_BASE))
		else $error("base address not loaded");
	a_load_mac: assert property (r_q.ld == LD_WAIT && EE_ACK && r_q.ld_cnt == 2'h1 |=>
		r_q.mac_low == $past(EE_DATA) ##[1:64] !busy)
		else $error("MAC preload stalled or wrong");

	// Upper byte writes of the configuration halves
	logic ctrl_wr;
	logic mac_wr;
	assign ctrl_wr = acc_ok && wr_ev && r_q.bank == BANK_CTRL && r_q.req_s2.be[1];
	assign mac_wr  = acc_ok && wr_ev && r_q.bank == BANK_MAC && r_q.req_s2.be[3];

	sequence s_wmark_wr;
		ctrl_wr && r_q.req_s2.addr[3:2] == 2'h1;
	endsequence

	sequence s_burst_wr;
		ctrl_wr && r_q.req_s2.addr[3:2] == 2'h2;
	endsequence

	// Reset values seen at the first edge after release
	a_bank_reset: assert property ($fell(SRST) |->
		BANK_SELECT == BANK_RESET && LOAD_BUSY)
		else $error("bank selector not reset");
	a_cfg_reset: assert property ($fell(SRST) |->
		!RX_WM_2KB && BURST_LENGTH == BURST_RESET)
		else $error("watermark or burst not reset");

	// Field writes reach the ports one cycle later
	a_wmark_write: assert property (s_wmark_wr |=>
		RX_WM_2KB == $past(r_q.req_s2.wdata[POS_WMARK]))
		else $error("watermark write lost");
	a_burst_write: assert property (s_burst_wr |=>
		BURST_LENGTH == $past(r_q.req_s2.wdata[POS_BURST +: 3]))
		else $error("burst length write lost");
	a_mac_mid: assert property (mac_wr && r_q.req_s2.addr[3:2] == 2'h0 |=>
		HOST_MAC[31:24] == $past(r_q.req_s2.wdata[31:24]))
		else $error("MAC middle word write lost");

	// Empty banks answer zero away from the selector
	a_bank_empty: assert property (acc_ok && rd_ev && r_q.bank != BANK_CTRL
		&& r_q.bank != BANK_MAC && r_q.req_s2.addr[3:2] != 2'h3 |=>
		HOST_RDATA == 32'h0000_0000)
		else $error("empty bank returned data");

endmodule : hbr_banked_regs

// >>> verif/hbr_banked_regs_bench.sv
// Purpose: Self-checking bench for the banked host register block.
// Assumes: Strobes held 6 cycles, then low 5 cycles between accesses.
// Notes:   Read data lanes follow the byte enables of the access.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module hbr_banked_regs_bench
	import hbr_pkg::*;
;
	typedef struct packed {
		logic        w;
		logic [15:0] a;
		logic [3:0]  b;
		logic [31:0] d;
		logic [31:0] m;
		logic [31:0] x;
	} hbr_row_t;
	logic          clk = 1'b0;
	logic          srst, sx, ax, strap, ee_ack, vld;
	hbr_host_req_t req;
	logic [15:0]   ee_data;
	logic [31:0]   rdata, got;
	logic          rvalid, busy, ee_req, wm;
	logic [1:0]    ee_word;
	logic [5:0]    bank;
	logic [2:0]    burst;
	logic [47:0]   mac;
	int            err_total = 0;
	int            n_checks = 0;
	logic [2:0]    codes [4] = '{3'h0, 3'h3, 3'h5, 3'h7};
	hbr_row_t      rows [18] = '{
		'{1'b0, 16'h030C, 4'hC, 0, 32'hFFFF0000, 0},
		'{1'b0, 16'h0300, 4'h3, 0, 32'h0000FFFF, 32'h0300},
		'{1'b0, 16'h0304, 4'hF, 0, 32'h8400FFFF, 0},
		'{1'b0, 16'h0308, 4'h3, 0, 32'h0000FFFF, 0},
		'{1'b1, 16'h0304, 4'hF, 32'h1000, 0, 0},
		'{1'b0, 16'h0304, 4'h3, 0, 32'h0000FFFF, 32'h1000},
		'{1'b1, 16'h030C, 4'hF, 32'h0002FFFF, 0, 0},
		'{1'b0, 16'h030C, 4'hF, 0, 32'hFFFFFFFF, 32'h00020000},
		'{1'b1, 16'h030C, 4'h4, 32'h00010000, 0, 0},
		'{1'b0, 16'h0300, 4'hF, 0, 32'hFFFFFFFF, 0},
		'{1'b0, 16'h0308, 4'hF, 0, 32'hFFFFFFFF, 0},
		'{1'b0, 16'h030C, 4'hC, 0, 32'hFFFF0000, 32'h00010000},
		'{1'b1, 16'h030C, 4'hC, 32'h00020000, 0, 0},
		'{1'b1, 16'h0300, 4'hF, 32'h456789AB, 0, 0},
		'{1'b1, 16'h0304, 4'h3, 32'h0123, 0, 0},
		'{1'b0, 16'h0300, 4'hF, 0, 32'hFFFFFFFF, 32'h456789AB},
		'{1'b0, 16'h0304, 4'h3, 0, 32'h0000FFFF, 32'h0123},
		'{1'b1, 16'h030C, 4'hC, 0, 0, 0}};
	// Free running clock
	always #25 clk = ~clk;
	hbr_banked_regs u_dut (.CLK(clk), .SRST(srst), .HOST_REQ(req), .HOST_SYNC_XFER(sx),
		.HOST_ASYNC_XFER(ax), .EEPROM_ENABLE_PIN(strap), .EE_ACK(ee_ack),
		.EE_DATA(ee_data), .HOST_RDATA(rdata), .HOST_RVALID(rvalid), .LOAD_BUSY(busy),
		.EE_REQ(ee_req), .EE_WORD(ee_word), .BANK_SELECT(bank), .RX_WM_2KB(wm),
		.BURST_LENGTH(burst), .HOST_MAC(mac));
	hbr_ee_model #(.DELAY(2)) u_ee (.CLK(clk), .SRST(srst), .EE_REQ(ee_req),
		.EE_WORD(ee_word), .EE_ACK(ee_ack), .EE_DATA(ee_data));
	// ----------------------------------------------------------------
	// Host bus tasks
	// ----------------------------------------------------------------
	// Qualifiers held over the whole strobe, so late sync never sees a change
	task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] b,
		input logic [31:0] d);
		vld = 1'b0;
		req.addr <= a;
		req.be <= b;
		req.wdata <= d;
		@(posedge clk);
		req.wr <= w;
		req.rd <= !w;
		repeat (6) begin
			@(posedge clk);
			if (rvalid === 1'b1) begin
				vld = 1'b1;
				got = rdata;
			end
		end
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : acc
	task automatic rd(input logic [15:0] a, input logic [3:0] b, input logic [31:0] m, x);
		acc(1'b0, a, b, '0);
		`CHK(vld, 1'b1)
		`CHK(got & m, x)
	endtask : rd
	task automatic print_verdict();
		if (err_total == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict
	// Bounded wait for the preload to finish
	task automatic do_reset(input logic s);
		int i;
		strap <= s;
		srst <= 1'b1;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		for (i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
		if (busy !== 1'b0) begin
			err_total++;
			print_verdict();
		end
	endtask : do_reset
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		req <= '0;
		sx <= 1'b0;
		ax <= 1'b0;
		do_reset(1'b0);
		// reserved bits kept as read back
		foreach (rows[i]) begin
			if (rows[i].w) acc(1'b1, rows[i].a, rows[i].b, rows[i].d);
			else rd(rows[i].a, rows[i].b, rows[i].m, rows[i].x);
		end
		`CHK(wm, 1'b1)
		`CHK(mac, 48'h0123456789AB)
		foreach (codes[k]) begin
			acc(1'b1, 16'h0308, 4'hF, {17'h0, codes[k], 12'h000});
			`CHK(burst, codes[k])
			rd(16'h0308, 4'h3, 32'hFFFF, {17'h0, codes[k], 12'h000});
		end
		// moved base, bit 5 miss, bit 4 ignored
		acc(1'b1, 16'h0300, 4'h3, 32'h0360);
		acc(1'b0, 16'h034C, 4'hC, '0);
		`CHK(vld, 1'b0)
		rd(16'h037C, 4'hC, 32'hFFFF0000, 0);
		rd(16'h0360, 4'h3, 32'hFFFF, 32'h0360);
		acc(1'b1, 16'h0360, 4'h3, 32'h0300);
		acc(1'b0, 16'h0300, 4'h5, '0);
		`CHK(got, 32'h0)
		`CHK(vld, 1'b1)
		rd(16'h0304, 4'hC, 32'hF8000000, 32'hA8000000);
		acc(1'b1, 16'h0300, 4'h6, 32'hFFFFFFFF);
		rd(16'h0304, 4'hC, 32'hF8000000, 32'hA8000000);
		rd(16'h0300, 4'h3, 32'hFFFF, 32'h0300);
		acc(1'b1, 16'h0304, 4'hC, 32'h0);
		rd(16'h0304, 4'hC, 32'hF8000000, 32'hA8000000);
		acc(1'b1, 16'h0304, 4'hC, 32'h80000000);
		rd(16'h0304, 4'hC, 32'h80000000, 0);
		sx <= 1'b1;
		ax <= 1'b1;
		repeat (4) @(posedge clk);
		// Clear lands while both kinds still run: set must win
		acc(1'b1, 16'h0304, 4'hC, 32'h04000000);
		sx <= 1'b0;
		ax <= 1'b0;
		rd(16'h0304, 4'hC, 32'h04000000, 32'h04000000);
		acc(1'b1, 16'h0304, 4'hC, 32'h04000000);
		rd(16'h0304, 4'hC, 32'h04000000, 0);
		do_reset(1'b1);
		`CHK(mac, 48'h0123456789AB)
		`CHK({bank, wm, burst}, 10'h0)
		rd(16'h0360, 4'h3, 32'hFFFF, 32'h0360);
		print_verdict();
	end
endmodule : hbr_banked_regs_bench

// >>> verif/hbr_ee_model.sv
// Purpose: EEPROM word reader model feeding the preload port.
// Assumes: One request at a time, held until acknowledged.
// Notes:   DELAY sets how slowly each word comes back.
`timescale 1ns/1ps
module hbr_ee_model #(
	parameter int DELAY = 2
)(
	input  wire logic        CLK,
	input  wire logic        SRST,
	input  wire logic        EE_REQ,
	input  wire logic [1:0]  EE_WORD,
	output logic             EE_ACK,
	output logic [15:0]      EE_DATA
);
	// ----------------------------------------------------------------
	// Word store and reply
	// ----------------------------------------------------------------
	// no write path
	logic [15:0] mem [4] = '{16'h0375, 16'h89AB, 16'h4567, 16'h0123};
	int          cnt = 0;
	initial EE_ACK = 1'b0;
	initial EE_DATA = 16'hA5A5;
	// Data inverts when not valid, so a late sample never looks right
	always @(posedge CLK) begin
		EE_ACK <= 1'b0;
		EE_DATA <= ~EE_DATA;
		if (SRST || !EE_REQ || EE_ACK) begin
			cnt <= 0;
		end else if (cnt == DELAY) begin
			EE_ACK <= 1'b1;
			EE_DATA <= mem[EE_WORD];
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : hbr_ee_model
